/* File: rtl/s1cb_top.sv */
// stage 1 bank slice: fault control reset, attribute lookup, translate commands
// Behaviour
// [RULE_01] stalled-transaction flag reads 0 after reset
// [RULE_02] context fault interrupt enable reads 0 after reset
// [RULE_03] context fault report enable reads 0 after reset
// [RULE_04] three-bit index picks one attribute byte from two indirection words
// [RULE_05] index bit 2 low selects register 0, high selects register 1
// [RULE_06] index bits 1:0 select byte i at bits 8i+7 down to 8i
// [RULE_07] read and write allocate bits: 0 no allocate, 1 allocate
// [RULE_08] outer nibble 0000 strong/device, 0100 outer non-cacheable
// [RULE_09] outer 00RW write-through transient, 01RW write-back transient, RW=00 unsupported
// [RULE_10] outer 10RW write-through, 11RW write-back non-transient
// [RULE_11] transient passed outward only as a hint
// [RULE_12] with outer zero: inner 0000 strong, 0100 device, others unpredictable
// [RULE_13] with outer nonzero: inner 0100 non-cacheable, 0000 unpredictable
// [RULE_14] with outer nonzero: inner 00RW/01RW transient write-through/write-back
// [RULE_15] with outer nonzero: inner 10RW/11RW non-transient write-through/write-back
// [RULE_16] multi-format register layout follows extended address enable
// [RULE_17] translate command translates address and fills result register
// [RULE_18] command locations are write-only, reads return zero
// [RULE_19] command address in bits 31:12, low bits reserved
// [RULE_20] auxiliary control is a 32-bit read-write register
// [RULE_21] identification register reports stage 1 support
// [RULE_22] active status bit is 1 until result register updated
// [RULE_23] other fields have no promised reset value
// [RULE_24] command privilege and direction go with the translation request
`timescale 1ns/1ps
`default_nettype none
`include "s1cb_map.svh"
module s1cb_top (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] awaddr,
  input wire logic [2:0] awprot,
  // axi4-lite write data
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // axi4-lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // axi4-lite read address
  input wire logic arvalid,
  output logic arready,
  input wire logic [31:0] araddr,
  input wire logic [2:0] arprot,
  // axi4-lite read data
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // translation request to the walker
  output logic xlat_req_valid,
  input wire logic xlat_req_ready,
  output logic [19:0] xlat_req_page,
  output logic xlat_req_priv,
  output logic xlat_req_write,
  // translation answer from the walker
  input wire logic xlat_rsp_valid,
  input wire logic [19:0] xlat_rsp_page,
  input wire logic [2:0] xlat_rsp_attr_index_a,
  input wire logic xlat_rsp_fault,
  // stall event from the fault logic
  input wire logic stall_event,
  // control levels
  output logic context_fault_irq_enable,
  output logic context_fault_report_enable,
  output logic extended_address_enable,
  output logic [31:0] aux_control,
  // decoded attributes of the last translation
  output s1cb_pkg::s1cb_mem_t res_outer_kind,
  output s1cb_pkg::s1cb_mem_t res_inner_kind,
  output logic [3:0] res_alloc,
  output logic [1:0] res_transient,
  output logic res_unpredictable
);
  import s1cb_pkg::*;

  // ==========================================================
  // state
  logic aw_held;
  logic w_held;
  logic [11:0] aw_off;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic next_aw_held;
  logic next_w_held;
  logic next_bvalid;
  logic next_rvalid;
  logic do_write;
  logic [31:0] table_base_control_reg;
  logic [31:0] attr_indirection_reg0;
  logic [31:0] attr_indirection_reg1;
  logic [31:0] phys_addr_result_reg;
  logic stall_flag;
  s1cb_xl_state_t xl_state;
  logic [7:0] sel_attr;
  s1cb_mem_t dec_outer;
  s1cb_mem_t dec_inner;
  logic dec_ord;
  logic dec_owa;
  logic dec_ird;
  logic dec_iwa;
  logic dec_otr;
  logic dec_itr;
  logic dec_unp;
  logic [31:0] rd_word;
  logic rd_hit;
  logic wr_hit;
  logic is_cmd;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    merge = old;
    for (int b = 0; b < 4; b = b + 1) begin
      if (strb[b]) begin
        merge[8*b +: 8] = nw[8*b +: 8];
      end
    end
  endfunction

  // ==========================================================
  // write channel
  assign do_write = aw_held && w_held && !bvalid;

  always_comb begin
    next_aw_held = aw_held;
    next_w_held = w_held;
    next_bvalid = bvalid;
    if (awvalid && awready) begin
      next_aw_held = 1'b1;
    end
    if (wvalid && wready) begin
      next_w_held = 1'b1;
    end
    if (do_write) begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
    end else if (bvalid && bready) begin
      next_bvalid = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      bvalid <= 1'b0;
      awready <= 1'b0;
      wready <= 1'b0;
      aw_off <= 12'h000;
      w_data <= `S1CB_RST_WORD;
      w_strb <= 4'h0;
    end else begin
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      bvalid <= next_bvalid;
      // a new write is taken only once the last response is gone
      awready <= !next_aw_held && !next_bvalid;
      wready <= !next_w_held && !next_bvalid;
      if (awvalid && awready) begin
        aw_off <= awaddr[11:0];
      end
      if (wvalid && wready) begin
        w_data <= wdata;
        w_strb <= wstrb;
      end
    end
  end

  always_comb begin
    is_cmd = (aw_off == `S1CB_OFF_CMD_PR) || (aw_off == `S1CB_OFF_CMD_PW) ||
             (aw_off == `S1CB_OFF_CMD_UR) || (aw_off == `S1CB_OFF_CMD_UW);
    wr_hit = is_cmd || (aw_off == `S1CB_OFF_SYS_CTRL) || (aw_off == `S1CB_OFF_AUX_CTRL) ||
             (aw_off == `S1CB_OFF_TBL_CTRL) || (aw_off == `S1CB_OFF_ATTR0) ||
             (aw_off == `S1CB_OFF_ATTR1) || (aw_off == `S1CB_OFF_PAR) ||
             (aw_off == `S1CB_OFF_FSR) || (aw_off == `S1CB_OFF_ID0) ||
             (aw_off == `S1CB_OFF_XSTAT);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bresp <= `S1CB_RESP_OKAY;
    end else if (do_write) begin
      bresp <= wr_hit ? `S1CB_RESP_OKAY : `S1CB_RESP_SLVERR;
    end
  end

  // ==========================================================
  // control registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      context_fault_irq_enable <= 1'b0; // RULE_02
      context_fault_report_enable <= 1'b0; // RULE_03
    end else if (do_write && aw_off == `S1CB_OFF_SYS_CTRL && w_strb[0]) begin
      context_fault_irq_enable <= w_data[`S1CB_BIT_IRQ_EN];
      context_fault_report_enable <= w_data[`S1CB_BIT_REPORT_EN];
    end
  end

  // other fields carry no promised value; zero is used for determinism
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aux_control <= `S1CB_RST_WORD; // RULE_23
      table_base_control_reg <= `S1CB_RST_WORD; // RULE_23
      attr_indirection_reg0 <= `S1CB_RST_WORD;
      attr_indirection_reg1 <= `S1CB_RST_WORD;
    end else if (do_write) begin
      if (aw_off == `S1CB_OFF_AUX_CTRL) begin
        aux_control <= merge(aux_control, w_data, w_strb); // RULE_20
      end
      if (aw_off == `S1CB_OFF_TBL_CTRL) begin
        table_base_control_reg <= merge(table_base_control_reg, w_data, w_strb);
      end
      if (aw_off == `S1CB_OFF_ATTR0) begin
        attr_indirection_reg0 <= merge(attr_indirection_reg0, w_data, w_strb);
      end
      if (aw_off == `S1CB_OFF_ATTR1) begin
        attr_indirection_reg1 <= merge(attr_indirection_reg1, w_data, w_strb);
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      extended_address_enable <= 1'b0;
    end else begin
      extended_address_enable <= table_base_control_reg[`S1CB_BIT_EXT_ADDR];
    end
  end

  // stall flag: hardware set beats a software write-one clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stall_flag <= 1'b0; // RULE_01
    end else if (stall_event) begin
      stall_flag <= 1'b1;
    end else if (do_write && aw_off == `S1CB_OFF_FSR && w_strb[3] && w_data[`S1CB_BIT_SS]) begin
      stall_flag <= 1'b0;
    end
  end

  // ==========================================================
  // translate commands
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      xl_state <= S1CB_XL_IDLE;
      xlat_req_valid <= 1'b0;
      xlat_req_page <= 20'h00000;
      xlat_req_priv <= 1'b0;
      xlat_req_write <= 1'b0;
    end else begin
      unique case (xl_state)
        S1CB_XL_IDLE: begin
          // a command while one is active is dropped
          if (do_write && is_cmd && `S1CB_STAGE1_PRESENT) begin // RULE_17
            xl_state <= S1CB_XL_REQ;
            xlat_req_valid <= 1'b1;
            xlat_req_page <= w_data[31:`S1CB_CMD_ADDR_LSB]; // RULE_19
            xlat_req_priv <= (aw_off == `S1CB_OFF_CMD_PR) ||
                             (aw_off == `S1CB_OFF_CMD_PW); // RULE_24
            xlat_req_write <= (aw_off == `S1CB_OFF_CMD_PW) ||
                              (aw_off == `S1CB_OFF_CMD_UW); // RULE_24
          end
        end
        S1CB_XL_REQ: begin
          if (xlat_req_ready) begin
            xlat_req_valid <= 1'b0;
            xl_state <= S1CB_XL_WAIT;
          end
        end
        S1CB_XL_WAIT: begin
          if (xlat_rsp_valid) begin
            xl_state <= S1CB_XL_IDLE; // RULE_22
          end
        end
      endcase
    end
  end

  s1cb_attr_select u_sel (
    .attr_indirection_reg0(attr_indirection_reg0),
    .attr_indirection_reg1(attr_indirection_reg1),
    .attr_index_a(xlat_rsp_attr_index_a),
    .entry_attr_field(sel_attr)
  );

  s1cb_attr_decode u_dec (
    .attr(sel_attr),
    .outer_kind(dec_outer),
    .outer_rd_alloc(dec_ord),
    .outer_wr_alloc(dec_owa),
    .outer_transient(dec_otr),
    .inner_kind(dec_inner),
    .inner_rd_alloc(dec_ird),
    .inner_wr_alloc(dec_iwa),
    .inner_transient(dec_itr),
    .unpredictable(dec_unp)
  );

  // result is written in the same edge that drops the active bit
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phys_addr_result_reg <= `S1CB_RST_WORD;
      res_outer_kind <= S1CB_MEM_STRONG;
      res_inner_kind <= S1CB_MEM_STRONG;
      res_alloc <= 4'h0;
      res_transient <= 2'h0;
      res_unpredictable <= 1'b0;
    end else if (xl_state == S1CB_XL_WAIT && xlat_rsp_valid) begin
      phys_addr_result_reg <= `S1CB_RST_WORD;
      phys_addr_result_reg[31:`S1CB_CMD_ADDR_LSB] <= xlat_rsp_page; // RULE_17
      phys_addr_result_reg[`S1CB_BIT_PAR_FAULT] <= xlat_rsp_fault;
      if (extended_address_enable) begin
        phys_addr_result_reg[`S1CB_PAR_ATTR_LSB +: 8] <= sel_attr; // RULE_16
      end
      res_outer_kind <= dec_outer;
      res_inner_kind <= dec_inner;
      res_alloc <= {dec_ord, dec_owa, dec_ird, dec_iwa}; // RULE_07
      res_transient <= {dec_otr, dec_itr}; // RULE_11
      res_unpredictable <= dec_unp;
    end
  end

  // ==========================================================
  // read channel
  always_comb begin
    rd_word = `S1CB_RST_WORD;
    rd_hit = 1'b1;
    unique case (araddr[11:0])
      `S1CB_OFF_SYS_CTRL: begin
        rd_word[`S1CB_BIT_IRQ_EN] = context_fault_irq_enable;
        rd_word[`S1CB_BIT_REPORT_EN] = context_fault_report_enable;
      end
      `S1CB_OFF_AUX_CTRL: rd_word = aux_control;
      `S1CB_OFF_TBL_CTRL: rd_word = table_base_control_reg;
      `S1CB_OFF_ATTR0: rd_word = attr_indirection_reg0;
      `S1CB_OFF_ATTR1: rd_word = attr_indirection_reg1;
      `S1CB_OFF_PAR: rd_word = phys_addr_result_reg;
      `S1CB_OFF_FSR: rd_word[`S1CB_BIT_SS] = stall_flag;
      `S1CB_OFF_ID0: rd_word[`S1CB_BIT_STAGE1] = `S1CB_STAGE1_PRESENT; // RULE_21
      `S1CB_OFF_XSTAT: rd_word[`S1CB_BIT_ACTIVE] = (xl_state != S1CB_XL_IDLE); // RULE_22
      `S1CB_OFF_CMD_PR, `S1CB_OFF_CMD_PW,
      `S1CB_OFF_CMD_UR, `S1CB_OFF_CMD_UW: rd_word = `S1CB_RST_WORD; // RULE_18
      default: rd_hit = 1'b0;
    endcase
  end

  always_comb begin
    next_rvalid = rvalid;
    if (arvalid && arready) begin
      next_rvalid = 1'b1;
    end else if (rvalid && rready) begin
      next_rvalid = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      arready <= 1'b0;
      rdata <= `S1CB_RST_WORD;
      rresp <= `S1CB_RESP_OKAY;
    end else begin
      rvalid <= next_rvalid;
      arready <= !next_rvalid;
      if (arvalid && arready) begin
        rdata <= rd_word;
        rresp <= rd_hit ? `S1CB_RESP_OKAY : `S1CB_RESP_SLVERR;
      end
    end
  end

endmodule
`default_nettype wire

/* File: rtl/s1cb_map.svh */
// register offsets, field positions and reset values of the stage 1 bank slice
`ifndef S1CB_MAP_SVH
`define S1CB_MAP_SVH

// byte offsets within the bank
`define S1CB_OFF_SYS_CTRL 12'h000
`define S1CB_OFF_AUX_CTRL 12'h004
`define S1CB_OFF_TBL_CTRL 12'h030
`define S1CB_OFF_ATTR0 12'h038
`define S1CB_OFF_ATTR1 12'h03C
`define S1CB_OFF_PAR 12'h050
`define S1CB_OFF_FSR 12'h058
`define S1CB_OFF_ID0 12'h0F0
`define S1CB_OFF_CMD_PR 12'h800
`define S1CB_OFF_CMD_PW 12'h808
`define S1CB_OFF_CMD_UR 12'h810
`define S1CB_OFF_CMD_UW 12'h818
`define S1CB_OFF_XSTAT 12'h8F0

// field positions
`define S1CB_BIT_REPORT_EN 5
`define S1CB_BIT_IRQ_EN 6
`define S1CB_BIT_EXT_ADDR 31
`define S1CB_BIT_SS 30
`define S1CB_BIT_ACTIVE 0
`define S1CB_BIT_STAGE1 29
`define S1CB_BIT_PAR_FAULT 0
`define S1CB_PAR_ATTR_LSB 4
`define S1CB_CMD_ADDR_LSB 12

// reset values
`define S1CB_RST_WORD 32'h0000_0000
`define S1CB_STAGE1_PRESENT 1'h1

// bus responses
`define S1CB_RESP_OKAY 2'h0
`define S1CB_RESP_SLVERR 2'h2

`endif

/* File: rtl/s1cb_pkg.sv */
// types shared by the stage 1 bank slice
`default_nettype none
package s1cb_pkg;

  typedef enum logic [2:0] {
    S1CB_XL_IDLE = 3'h1,
    S1CB_XL_REQ = 3'h2,
    S1CB_XL_WAIT = 3'h4
  } s1cb_xl_state_t;

  typedef enum logic [2:0] {
    S1CB_MEM_STRONG = 3'h0,
    S1CB_MEM_DEVICE = 3'h1,
    S1CB_MEM_NONCACHE = 3'h2,
    S1CB_MEM_WTHRU = 3'h3,
    S1CB_MEM_WBACK = 3'h4
  } s1cb_mem_t;

endpackage
`default_nettype wire

/* File: rtl/s1cb_attr_select.sv */
// picks one attribute byte out of the two indirection registers
`timescale 1ns/1ps
`default_nettype none
module s1cb_attr_select (
  // indirection registers
  input wire logic [31:0] attr_indirection_reg0,
  input wire logic [31:0] attr_indirection_reg1,
  // index from the table entry
  input wire logic [2:0] attr_index_a,
  // selected field
  output logic [7:0] entry_attr_field
);
  logic [7:0] field [0:7];

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_byte
      assign field[g] = attr_indirection_reg0[8*g+7 -: 8]; // RULE_06
      assign field[g+4] = attr_indirection_reg1[8*g+7 -: 8]; // RULE_06
    end
  endgenerate

  // index bit 2 chooses register 1 over register 0
  assign entry_attr_field = field[attr_index_a]; // RULE_04 RULE_05
endmodule
`default_nettype wire

/* File: rtl/s1cb_attr_decode.sv */
// splits an attribute byte into outer and inner memory kinds
`timescale 1ns/1ps
`default_nettype none
module s1cb_attr_decode
  import s1cb_pkg::*;
(
  // attribute byte
  input wire logic [7:0] attr,
  // outer half
  output s1cb_pkg::s1cb_mem_t outer_kind,
  output logic outer_rd_alloc,
  output logic outer_wr_alloc,
  output logic outer_transient,
  // inner half
  output s1cb_pkg::s1cb_mem_t inner_kind,
  output logic inner_rd_alloc,
  output logic inner_wr_alloc,
  output logic inner_transient,
  // encoding outside the defined set
  output logic unpredictable
);
  logic [3:0] hi;
  logic [3:0] lo;
  logic hi_zero;

  assign hi = attr[7:4];
  assign lo = attr[3:0];
  assign hi_zero = (hi == 4'h0);

  function automatic s1cb_mem_t kind_of(input logic [3:0] n);
    if (n == 4'h4) begin
      kind_of = S1CB_MEM_NONCACHE;
    end else if (n[2]) begin
      kind_of = S1CB_MEM_WBACK;
    end else begin
      kind_of = S1CB_MEM_WTHRU;
    end
  endfunction

  always_comb begin
    // allocate bits mean allocate when set
    outer_rd_alloc = hi[1] & (hi != 4'h4) & ~hi_zero; // RULE_07
    outer_wr_alloc = hi[0] & (hi != 4'h4) & ~hi_zero; // RULE_07
    inner_rd_alloc = lo[1] & (lo != 4'h4) & ~hi_zero; // RULE_07
    inner_wr_alloc = lo[0] & (lo != 4'h4) & ~hi_zero; // RULE_07
    // transient is only a hint carried outward
    outer_transient = ~hi[3] & (hi[1:0] != 2'h0); // RULE_09 RULE_11
    inner_transient = ~hi_zero & ~lo[3] & (lo[1:0] != 2'h0); // RULE_14 RULE_11
    unpredictable = 1'b0;
    if (hi_zero) begin
      // strongly ordered or device, told apart by the low half
      outer_kind = (lo == 4'h4) ? S1CB_MEM_DEVICE : S1CB_MEM_STRONG; // RULE_08
      inner_kind = outer_kind; // RULE_12
      unpredictable = (lo != 4'h0) && (lo != 4'h4); // RULE_12
    end else begin
      outer_kind = kind_of(hi); // RULE_08 RULE_09 RULE_10
      inner_kind = kind_of(lo); // RULE_13 RULE_14 RULE_15
      unpredictable = (lo == 4'h0) || (hi[3:2] == 2'h0 && hi[1:0] == 2'h0); // RULE_13
    end
  end
endmodule
`default_nettype wire

/* File: tb/s1cb_assertions.sv */
// bound checker for the stage 1 bank slice ports
`timescale 1ns/1ps
`default_nettype none
module s1cb_checker (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register bus
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [31:0] rdata,
  // translation link
  input wire logic xlat_req_valid,
  input wire logic xlat_req_ready,
  input wire logic [19:0] xlat_req_page,
  input wire logic xlat_rsp_valid,
  // levels and results
  input wire logic context_fault_irq_enable,
  input wire logic context_fault_report_enable,
  input wire logic extended_address_enable,
  input wire logic [3:0] res_alloc,
  input wire logic [1:0] res_transient
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ==========================================
  // checks
  reset_clear_en_a: assert property ($rose(aresetn) |->
    !context_fault_irq_enable && !context_fault_report_enable) else $error("enables set");
  b_hold_a: assert property (bvalid && !bready |=> bvalid) else $error("bvalid dropped");
  r_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data not held");
  b_after_both_a: assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid)
    else $error("no write response");
  aw_blocked_a: assert property (bvalid |-> !awready && !wready) else $error("ready in resp");
  ar_blocked_a: assert property (rvalid |-> !arready) else $error("arready in read");
  req_hold_a: assert property (xlat_req_valid && !xlat_req_ready |=>
    xlat_req_valid && $stable(xlat_req_page)) else $error("request not held");
  req_from_cmd_a: assert property ($rose(xlat_req_valid) |-> $rose(bvalid))
    else $error("request without command");
  res_from_rsp_a: assert property ($changed({res_alloc, res_transient}) |->
    $past(xlat_rsp_valid)) else $error("result moved without answer");
  ext_addr_from_write_a: assert property ($changed(extended_address_enable) |->
    $past(bvalid)) else $error("format bit moved without write");
endmodule
bind s1cb_top s1cb_checker u_checker (.aclk, .aresetn, .awvalid, .awready, .wvalid, .wready,
  .bvalid, .bready, .arready, .rvalid, .rready, .rdata, .xlat_req_valid, .xlat_req_ready,
  .xlat_req_page, .xlat_rsp_valid, .context_fault_irq_enable, .context_fault_report_enable,
  .extended_address_enable, .res_alloc, .res_transient);
`default_nettype wire

/* File: tb/testbench.sv */
// self-checking bench for the stage 1 bank slice
`timescale 1ns/1ps
`default_nettype none
`include "s1cb_map.svh"
module testbench;
  import s1cb_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic xlat_req_ready = 1'b0, xlat_rsp_valid = 1'b0, xlat_rsp_fault = 1'b0;
  logic stall_event = 1'b0;
  logic [19:0] xlat_rsp_page = 20'h0;
  logic [2:0] xlat_rsp_attr_index_a = 3'h0;
  logic awready, wready, bvalid, arready, rvalid, xlat_req_valid, xlat_req_priv, xlat_req_write;
  logic [1:0] bresp, rresp, res_transient;
  logic [31:0] rdata, aux_control, rd;
  logic [19:0] xlat_req_page;
  logic context_fault_irq_enable, context_fault_report_enable, extended_address_enable;
  logic res_unpredictable;
  logic [3:0] res_alloc;
  logic [1:0] rs;
  s1cb_mem_t res_outer_kind, res_inner_kind;
  int miscompares = 0;
  int checks_done = 0;
  int cycles = 0;
  localparam logic [31:0] ATTR0 = 32'hFF44_0400;
  localparam logic [31:0] ATTR1 = 32'h0170_26BA;
  localparam logic [2:0] IK [8] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h3, 3'h4, 3'h0, 3'h0};
  localparam logic [2:0] OK [8] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h3, 3'h3, 3'h0, 3'h0};
  localparam logic [5:0] AT [8] = '{6'h0, 6'h0, 6'h0, 6'h3C, 6'h38, 6'h2B, 6'h0, 6'h0};

  s1cb_top u_dut (.aclk, .aresetn, .awvalid, .awready, .awaddr, .awprot(3'h0), .wvalid,
    .wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr,
    .arprot(3'h0), .rvalid, .rready, .rdata, .rresp, .xlat_req_valid, .xlat_req_ready,
    .xlat_req_page, .xlat_req_priv, .xlat_req_write, .xlat_rsp_valid, .xlat_rsp_page,
    .xlat_rsp_attr_index_a, .xlat_rsp_fault, .stall_event, .context_fault_irq_enable,
    .context_fault_report_enable, .extended_address_enable, .aux_control, .res_outer_kind,
    .res_inner_kind, .res_alloc, .res_transient, .res_unpredictable);

  // ==========================================
  // clock, watchdog, reporting
  always #2 aclk = ~aclk;
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares = miscompares + 1;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // ==========================================
  // bus cycles
  task automatic axw(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    awaddr <= {20'h0, a};
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (!aw_ok && awready) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_ok && wready) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (!bvalid);
    bready <= 1'b1;
    do @(posedge aclk); while (!bvalid);
    rs = bresp;
    bready <= 1'b0;
  endtask
  task automatic axr(input logic [11:0] a);
    araddr <= {20'h0, a};
    arvalid <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    @(posedge aclk);
    rready <= 1'b1;
    do @(posedge aclk); while (!rvalid);
    rd = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask

  // ==========================================
  // scenarios
  task automatic t_reset();
    axr(`S1CB_OFF_SYS_CTRL);
    chk(rd[`S1CB_BIT_IRQ_EN], 1'b0);
    chk(rd[`S1CB_BIT_REPORT_EN], 1'b0);
    axr(`S1CB_OFF_FSR);
    chk(rd[`S1CB_BIT_SS], 1'b0);
    axr(`S1CB_OFF_ID0);
    chk(rd[`S1CB_BIT_STAGE1], 1'b1);
    axr(12'h100);
    chk(rs, `S1CB_RESP_SLVERR);
    axw(12'h100, 32'h0, 4'hF);
    chk(rs, `S1CB_RESP_SLVERR);
    axw(`S1CB_OFF_AUX_CTRL, 32'hA5C3_0F96, 4'hF);
    chk(rs, `S1CB_RESP_OKAY);
    axw(`S1CB_OFF_AUX_CTRL, 32'h0, 4'h2);
    axr(`S1CB_OFF_AUX_CTRL);
    chk(rd, 32'hA5C3_0096);
    chk(aux_control, 32'hA5C3_0096);
    axw(`S1CB_OFF_SYS_CTRL, 32'h60, 4'h1);
    chk({context_fault_irq_enable, context_fault_report_enable}, 2'h3);
    stall_event <= 1'b1;
    @(posedge aclk);
    stall_event <= 1'b0;
    axr(`S1CB_OFF_FSR);
    chk(rd[`S1CB_BIT_SS], 1'b1);
    axw(`S1CB_OFF_FSR, 32'h4000_0000, 4'h8);
    axr(`S1CB_OFF_FSR);
    chk(rd[`S1CB_BIT_SS], 1'b0);
    $display("test reset and control done");
  endtask
  task automatic xlat(input logic [2:0] i, input logic ext_on);
    logic [11:0] off;
    logic [19:0] pg;
    logic [31:0] sel;
    logic [7:0] ab;
    off = 12'h800 + {7'h0, i[1:0], 3'h0};
    pg = {i, 17'h1A5C3};
    sel = i[2] ? ATTR1 : ATTR0;
    ab = sel[8 * i[1:0] +: 8];
    axw(off, {pg, 12'h000}, 4'hF);
    chk(xlat_req_valid, 1'b1);
    chk(xlat_req_page, pg);
    chk({xlat_req_priv, xlat_req_write}, {~off[4], off[3]});
    axr(`S1CB_OFF_XSTAT);
    chk(rd[0], 1'b1);
    axr(off);
    chk(rd, 32'h0);
    axw(off, {~pg, 12'h000}, 4'hF);
    chk(xlat_req_page, pg);
    xlat_req_ready <= 1'b1;
    @(posedge aclk);
    xlat_req_ready <= 1'b0;
    xlat_rsp_valid <= 1'b1;
    xlat_rsp_page <= ~pg;
    xlat_rsp_attr_index_a <= i;
    xlat_rsp_fault <= i[0];
    @(posedge aclk);
    xlat_rsp_valid <= 1'b0;
    axr(`S1CB_OFF_PAR);
    chk(rd, {~pg, ext_on ? ab : 8'h0, 3'h0, i[0]});
    axr(`S1CB_OFF_XSTAT);
    chk(rd[0], 1'b0);
    chk(res_unpredictable, i[2] & i[1]);
    if (!(i[2] & i[1])) begin
      chk(res_inner_kind, IK[i]);
      chk({res_alloc, res_transient}, AT[i]);
      chk(res_outer_kind, OK[i]);
    end
  endtask
  task automatic t_attr();
    axw(`S1CB_OFF_ATTR0, ATTR0, 4'hF);
    axw(`S1CB_OFF_ATTR1, ATTR1, 4'hF);
    axw(`S1CB_OFF_TBL_CTRL, 32'h8000_0000, 4'hF);
    chk(extended_address_enable, 1'b1);
    for (int k = 0; k < 8; k++) begin
      xlat(k[2:0], 1'b1);
    end
    axw(`S1CB_OFF_TBL_CTRL, 32'h0, 4'hF);
    xlat(3'h3, 1'b0);
    $display("test attribute lookup and commands done");
  endtask

  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    t_reset();
    t_attr();
    give_verdict();
  end
endmodule
`default_nettype wire
